/* File: mpfc_pkg.sv */
// Purpose: constants for the mac pause flow control block
// Assumes: 10 MHz clock, 32-bit apb register words
// Notes:   offsets are byte addresses
package mpfc_pkg;
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          QUANTUM_NS    = 512;
    // a least time, so rounded up
    localparam int          QUANTUM_CYC   = (QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] REPEAT_TRIM   = 16'h0020;
    localparam logic [47:0] RESERVED_DA   = 48'h0180c2000001;
    localparam logic [15:0] CTRL_TYPE     = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE  = 16'h0001;
    localparam int          HDR_BYTES     = 18;
    localparam int          PAD_END       = 60;
    localparam int          FRAME_END     = 64;
    localparam logic [31:0] CRC_INIT      = 32'hffffffff;
    localparam logic [31:0] CRC_POLY      = 32'hedb88320;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFF      = 8'h00;
    localparam logic [7:0]  PTIME_OFF     = 8'h04;
    localparam logic [7:0]  STA_LO_OFF    = 8'h08;
    localparam logic [7:0]  STA_HI_OFF    = 8'h0c;
    localparam logic [7:0]  SRC_LO_OFF    = 8'h10;
    localparam logic [7:0]  SRC_HI_OFF    = 8'h14;
    localparam logic [7:0]  STATUS_OFF    = 8'h18;
    // control register fields
    localparam int          HONOUR_BIT    = 0;
    localparam int          BYPASS_BIT    = 1;
    localparam int          PIN_DIS_BIT   = 2;
    localparam int          FINAL_EN_BIT  = 3;
    localparam int          PASS_LSB      = 4;
    localparam int          THR_LSB       = 8;
    localparam logic [31:0] CTRL_RESET    = 32'h00000009;
    localparam logic [31:0] CTRL_MASK     = 32'h00000f3f;
    localparam logic [15:0] PTIME_RESET   = 16'hffff;
    // pass select encodings
    localparam logic [1:0]  PASS_NONE     = 2'h0;
    localparam logic [1:0]  PASS_ALL      = 2'h1;
    localparam logic [1:0]  PASS_NONPAUSE = 2'h2;
    localparam logic [1:0]  PASS_PAUSE    = 2'h3;
    typedef enum logic [1:0] {MPFC_GEN_IDLE, MPFC_GEN_ACTIVE} mpfc_gen_t;
endpackage : mpfc_pkg

/* File: mpfc_top.sv */
// Purpose: full-duplex pause flow control: rx pause decode, tx gating, pause generation
// Assumes: byte streams on CLOCK, apb register access
// Notes:   generated frames stream one byte per cycle with no back-pressure
//
// Summary of operation
// RULE_01: length/type 0x8808 marks a control frame: opcode then parameter.
// RULE_02: pause destination is the reserved multicast or our station address.
// RULE_03: a valid accepted pause stops regular packets for the given quanta.
// RULE_04: one quantum is 512 bit times, for received and generated pauses.
// RULE_05: a packet in flight finishes; later packets wait for the pause timer.
// RULE_06: control frames are consumed by default, not passed to the fifo.
// RULE_07: two-bit select passes all, non-pause only, or pause-only control frames.
// RULE_08: pause frames are sent on the request pin or fifo above threshold.
// RULE_09: received pause blocks regular packets only, never generated pause frames.
// RULE_10: a due pause frame waits for the current packet, then goes first.
// RULE_11: first pause frame loads repeat timer; resend while trigger holds at expiry.
// RULE_12: the repeat timer runs 32 quanta shorter than the programmed time.
// RULE_13: when triggers drop send a zero-time frame, unless that is disabled.
// RULE_14: source address and pause time come from software registers.
// RULE_15: request pin active after reset; the disable bit stops it.
// RULE_16: fifo trigger off after reset; nonzero four-bit threshold enables it.
// RULE_17: with the honour bit clear, received pauses are ignored.
// RULE_18: bypass bit makes any pause destination acceptable.
// RULE_19: each valid pause reloads the timer; zero releases at once.
// RULE_20: generated frames use reserved destination, control type, pause opcode, fcs.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module mpfc_top #(
    parameter int QUANTUM_CYC = mpfc_pkg::QUANTUM_CYC
) (
    input  wire logic        CLOCK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        PAUSE_REQUEST_PIN,
    input  wire logic [3:0]  RX_FIFO_LEVEL,
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_EOF,
    input  wire logic        RX_GOOD,
    output logic             RX_DONE,
    output logic             RX_IS_CTRL,
    output logic             RX_PASS,
    input  wire logic        TX_REQ,
    input  wire logic        TX_BUSY,
    output logic             TX_START,
    output logic             TX_PAUSED,
    output logic             PF_VALID,
    output logic      [7:0]  PF_DATA,
    output logic             PF_LAST
);
    logic [31:0]          ctrl_r;
    logic [15:0]          ptime_r;
    logic [47:0]          sta_r;
    logic [47:0]          src_r;
    logic                 req_s1_r;
    logic                 req_s2_r;
    logic [7:0]           qpre_r;
    logic                 qtick;
    logic [15:0]          rxq_r;
    logic [15:0]          repq_r;
    logic [4:0]           rxcnt_r;
    logic [143:0]         rxhdr_r;
    logic                 is_ctrl;
    logic                 is_pause;
    logic                 da_ok;
    logic                 pause_ok;
    logic                 pass_nxt;
    logic                 trig;
    mpfc_pkg::mpfc_gen_t  gen_r;
    logic                 due_r;
    logic                 zero_r;
    logic                 pf_on_r;
    logic [6:0]           idx_r;
    logic [6:0]           pf_len_r;
    logic [143:0]         txhdr_r;
    logic [31:0]          crc_r;
    logic                 pf_go;
    logic                 tx_go;
    logic                 wr;
    logic                 rd;
    logic [7:0]           pf_byte;
    logic [3:0]           thr;

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ mpfc_pkg::CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction : crc_step

    assign thr = ctrl_r[mpfc_pkg::THR_LSB +: 4];
    assign wr  = CE && PSEL && PENABLE && PWRITE && !PREADY;
    assign rd  = CE && PSEL && PENABLE && !PWRITE && !PREADY;

    // apb slave: one wait state, unmapped reads and writes above the status offset answer with an error
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else if (CE) begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
            if (rd) begin
                if (PADDR == mpfc_pkg::CTRL_OFF) begin
                    PRDATA <= ctrl_r;
                end else if (PADDR == mpfc_pkg::PTIME_OFF) begin
                    PRDATA <= {16'h0000, ptime_r};
                end else if (PADDR == mpfc_pkg::STA_LO_OFF) begin
                    PRDATA <= sta_r[31:0];
                end else if (PADDR == mpfc_pkg::STA_HI_OFF) begin
                    PRDATA <= {16'h0000, sta_r[47:32]};
                end else if (PADDR == mpfc_pkg::SRC_LO_OFF) begin
                    PRDATA <= src_r[31:0];
                end else if (PADDR == mpfc_pkg::SRC_HI_OFF) begin
                    PRDATA <= {16'h0000, src_r[47:32]};
                end else if (PADDR == mpfc_pkg::STATUS_OFF) begin
                    PRDATA <= {rxq_r, 14'h0000, gen_r == mpfc_pkg::MPFC_GEN_ACTIVE, TX_PAUSED};
                end else begin
                    PSLVERR <= 1'b1;
                end
            end else if (PSEL && PENABLE && !PREADY && PADDR > mpfc_pkg::STATUS_OFF) begin
                PSLVERR <= 1'b1;
            end
        end
    end

    // RULE_14 programmable fields
    // RULE_15 RULE_16 reset defaults
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_r  <= mpfc_pkg::CTRL_RESET;
            ptime_r <= mpfc_pkg::PTIME_RESET;
            sta_r   <= 48'h000000000000;
            src_r   <= 48'h000000000000;
        end else if (wr) begin
            if (PADDR == mpfc_pkg::CTRL_OFF) begin
                ctrl_r <= PWDATA & mpfc_pkg::CTRL_MASK;
            end else if (PADDR == mpfc_pkg::PTIME_OFF) begin
                ptime_r <= PWDATA[15:0];
            end else if (PADDR == mpfc_pkg::STA_LO_OFF) begin
                sta_r[31:0] <= PWDATA;
            end else if (PADDR == mpfc_pkg::STA_HI_OFF) begin
                sta_r[47:32] <= PWDATA[15:0];
            end else if (PADDR == mpfc_pkg::SRC_LO_OFF) begin
                src_r[31:0] <= PWDATA;
            end else if (PADDR == mpfc_pkg::SRC_HI_OFF) begin
                src_r[47:32] <= PWDATA[15:0];
            end
        end
    end

    // request pin is asynchronous
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else if (CE) begin
            req_s1_r <= PAUSE_REQUEST_PIN;
            req_s2_r <= req_s1_r;
        end
    end

    // RULE_04 quantum prescaler, shared by both timers
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            qpre_r <= 8'h00;
        end else if (CE) begin
            qpre_r <= qtick ? 8'h00 : qpre_r + 8'h01;
        end
    end
    assign qtick = qpre_r == 8'(QUANTUM_CYC - 1);

    // receive header capture
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rxcnt_r <= 5'h00;
            rxhdr_r <= '0;
        end else if (CE && RX_VALID) begin
            if (RX_EOF) begin
                rxcnt_r <= 5'h00;
            end else if (rxcnt_r < 5'(mpfc_pkg::HDR_BYTES)) begin
                rxcnt_r <= rxcnt_r + 5'h01;
                rxhdr_r <= {rxhdr_r[135:0], RX_DATA};
            end
        end
    end

    // RULE_01 control frame by type field
    assign is_ctrl  = rxcnt_r == 5'(mpfc_pkg::HDR_BYTES) && rxhdr_r[47:32] == mpfc_pkg::CTRL_TYPE;
    assign is_pause = is_ctrl && rxhdr_r[31:16] == mpfc_pkg::PAUSE_OPCODE;
    // RULE_02 RULE_18 destination check
    assign da_ok    = rxhdr_r[143:96] == mpfc_pkg::RESERVED_DA || rxhdr_r[143:96] == sta_r
                      || ctrl_r[mpfc_pkg::BYPASS_BIT];
    // RULE_17 honour bit gates the pause
    assign pause_ok = CE && RX_VALID && RX_EOF && RX_GOOD && is_pause && da_ok
                      && ctrl_r[mpfc_pkg::HONOUR_BIT];

    // RULE_06 RULE_07 fifo pass decision
    always_comb begin
        pass_nxt = 1'b1;
        if (is_ctrl) begin
            case (ctrl_r[mpfc_pkg::PASS_LSB +: 2])
                mpfc_pkg::PASS_ALL:      pass_nxt = 1'b1;
                mpfc_pkg::PASS_NONPAUSE: pass_nxt = !is_pause;
                mpfc_pkg::PASS_PAUSE:    pass_nxt = is_pause;
                default:                 pass_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            RX_DONE    <= 1'b0;
            RX_IS_CTRL <= 1'b0;
            RX_PASS    <= 1'b0;
        end else if (CE) begin
            RX_DONE    <= RX_VALID && RX_EOF;
            RX_IS_CTRL <= RX_VALID && RX_EOF && is_ctrl;
            RX_PASS    <= RX_VALID && RX_EOF && pass_nxt;
        end
    end

    // RULE_03 RULE_19 receive pause timer, reloaded by each valid pause
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rxq_r     <= 16'h0000;
            TX_PAUSED <= 1'b0;
        end else if (CE) begin
            if (pause_ok) begin
                rxq_r     <= rxhdr_r[15:0];
                TX_PAUSED <= rxhdr_r[15:0] != 16'h0000;
            end else if (qtick && rxq_r != 16'h0000) begin
                rxq_r     <= rxq_r - 16'h0001;
                TX_PAUSED <= rxq_r != 16'h0001;
            end
        end
    end

    // RULE_08 RULE_15 RULE_16 generation triggers
    assign trig = (req_s2_r && !ctrl_r[mpfc_pkg::PIN_DIS_BIT]) || (thr != 4'h0 && RX_FIFO_LEVEL > thr);

    // RULE_10 pause frame waits for packet in flight, then beats regular traffic
    // a start granted last cycle has not raised busy yet, so it blocks the frame too
    assign pf_go = CE && due_r && !pf_on_r && !TX_BUSY && !TX_START;
    // RULE_05 RULE_09 only regular starts are gated by the receive pause
    assign tx_go = CE && TX_REQ && !TX_BUSY && !TX_PAUSED && !due_r && !pf_on_r && !TX_START;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            TX_START <= 1'b0;
        end else if (CE) begin
            TX_START <= tx_go;
        end
    end

    // RULE_11 RULE_13 generation sequencing
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            gen_r  <= mpfc_pkg::MPFC_GEN_IDLE;
            due_r  <= 1'b0;
            zero_r <= 1'b0;
        end else if (CE) begin
            if (pf_go) begin
                due_r <= 1'b0;
            end
            case (gen_r)
                mpfc_pkg::MPFC_GEN_IDLE: begin
                    if (trig && !due_r) begin
                        gen_r  <= mpfc_pkg::MPFC_GEN_ACTIVE;
                        due_r  <= 1'b1;
                        zero_r <= 1'b0;
                    end
                end
                mpfc_pkg::MPFC_GEN_ACTIVE: begin
                    if (!due_r && !pf_on_r) begin
                        if (!trig) begin
                            gen_r  <= mpfc_pkg::MPFC_GEN_IDLE;
                            due_r  <= ctrl_r[mpfc_pkg::FINAL_EN_BIT];
                            zero_r <= 1'b1;
                        end else if (repq_r == 16'h0000) begin
                            due_r  <= 1'b1;
                            zero_r <= 1'b0;
                        end
                    end
                end
                default: gen_r <= mpfc_pkg::MPFC_GEN_IDLE;
            endcase
        end
    end

    // RULE_12 repeat timer trimmed to cover latency
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            repq_r <= 16'h0000;
        end else if (CE) begin
            if (pf_go && !zero_r) begin
                repq_r <= ptime_r > mpfc_pkg::REPEAT_TRIM ? ptime_r - mpfc_pkg::REPEAT_TRIM : 16'h0000;
            end else if (qtick && repq_r != 16'h0000) begin
                repq_r <= repq_r - 16'h0001;
            end
        end
    end

    // RULE_20 header bytes then zero pad then fcs low byte first
    always_comb begin
        if (idx_r < 7'(mpfc_pkg::HDR_BYTES)) begin
            pf_byte = txhdr_r[143:136];
        end else if (idx_r < 7'(mpfc_pkg::PAD_END)) begin
            pf_byte = 8'h00;
        end else begin
            pf_byte = ~crc_r[8 * (idx_r[1:0]) +: 8];
        end
    end

    // RULE_14 RULE_20 pause frame transmitter
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pf_on_r  <= 1'b0;
            idx_r    <= 7'h00;
            txhdr_r  <= '0;
            crc_r    <= mpfc_pkg::CRC_INIT;
            PF_VALID <= 1'b0;
            PF_DATA  <= 8'h00;
            PF_LAST  <= 1'b0;
        end else if (CE) begin
            PF_VALID <= pf_on_r;
            PF_DATA  <= pf_on_r ? pf_byte : 8'h00;
            PF_LAST  <= pf_on_r && idx_r == 7'(mpfc_pkg::FRAME_END - 1);
            if (pf_go) begin
                pf_on_r <= 1'b1;
                idx_r   <= 7'h00;
                crc_r   <= mpfc_pkg::CRC_INIT;
                txhdr_r <= {mpfc_pkg::RESERVED_DA, src_r, mpfc_pkg::CTRL_TYPE,
                            mpfc_pkg::PAUSE_OPCODE, zero_r ? 16'h0000 : ptime_r};
            end else if (pf_on_r) begin
                idx_r   <= idx_r + 7'h01;
                txhdr_r <= {txhdr_r[135:0], 8'h00};
                if (idx_r < 7'(mpfc_pkg::PAD_END)) begin
                    crc_r <= crc_step(crc_r, pf_byte);
                end
                if (idx_r == 7'(mpfc_pkg::FRAME_END - 1)) begin
                    pf_on_r <= 1'b0;
                end
            end
        end
    end

    // counts cycles the frame transmitter stays on, for the length check
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pf_len_r <= 7'h00;
        end else if (CE) begin
            pf_len_r <= pf_on_r ? pf_len_r + 7'h01 : 7'h00;
        end
    end

    // RULE_09 regular start never while paused
    no_start_paused_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_09
        TX_START |-> !$past(TX_PAUSED)) else $error("regular start while paused");
    pause_zero_rel_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_19
        pause_ok && rxhdr_r[15:0] == 16'h0000 |=> !TX_PAUSED) else $error("zero pause kept paused");
    pause_load_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_03
        pause_ok |=> rxq_r == $past(rxhdr_r[15:0])) else $error("pause quanta not loaded");
    ignore_pause_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_17
        !ctrl_r[mpfc_pkg::HONOUR_BIT] && !TX_PAUSED |=> !TX_PAUSED) else $error("pause honoured while off");
    default_drop_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_06
        RX_IS_CTRL && $past(ctrl_r[mpfc_pkg::PASS_LSB +: 2]) == mpfc_pkg::PASS_NONE |-> !RX_PASS)
        else $error("ctrl frame passed");
    pf_length_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_20
        $fell(pf_on_r) |-> pf_len_r == 7'(mpfc_pkg::FRAME_END)) else $error("pause frame length wrong");
    wait_busy_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_10
        $rose(pf_on_r) |-> !$past(TX_BUSY) && !$past(TX_START)) else $error("pause frame cut into packet");
    repeat_trim_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_12
        pf_go && !zero_r && ptime_r > mpfc_pkg::REPEAT_TRIM |=> repq_r == $past(ptime_r) - 16'h0020)
        else $error("repeat timer not trimmed");
    final_zero_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_13
        CE && gen_r == mpfc_pkg::MPFC_GEN_ACTIVE && !trig && !due_r && !pf_on_r
        |=> due_r == $past(ctrl_r[mpfc_pkg::FINAL_EN_BIT]) && zero_r) else $error("final frame wrong");
    trig_start_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE_08
        CE && gen_r == mpfc_pkg::MPFC_GEN_IDLE && trig && !due_r |=> due_r) else $error("trigger ignored");
    c_rx_pause_c: cover property (@(posedge CLOCK) disable iff (!RESET_N) $rose(TX_PAUSED));
    c_repeat_c:   cover property (@(posedge CLOCK) disable iff (!RESET_N) pf_go && !zero_r && repq_r == 16'h0000
        && gen_r == mpfc_pkg::MPFC_GEN_ACTIVE);
    c_zero_pf_c:  cover property (@(posedge CLOCK) disable iff (!RESET_N) pf_go && zero_r);
    c_pass_c:     cover property (@(posedge CLOCK) disable iff (!RESET_N) RX_IS_CTRL && RX_PASS);
endmodule : mpfc_top

/* File: mpfc_station.sv */
// Purpose: remote station model: sends control frames, occupies tx line
// Assumes: one byte per clock, 60-byte frames with good fcs
// Notes:   idle data toggles so stale bytes never look settled
`timescale 1ns/1ps
module mpfc_station (
    input  wire logic       clk,
    input  wire logic       tx_start,
    output logic            tx_busy,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_eof,
    output logic            rx_good
);
    int   busy_left = 0;
    logic sending   = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_eof   = 1'b0;
        rx_good  = 1'b0;
    end
    assign tx_busy = (busy_left > 0);
    // each permitted packet holds the line 8 cycles
    always @(posedge clk) begin
        if (tx_start) busy_left <= 8;
        else if (busy_left > 0) busy_left <= busy_left - 1;
        if (!sending) rx_data <= ~rx_data;
    end
    task automatic send_ctrl(input logic [47:0] da, input logic [15:0] op, input logic [15:0] q);
        logic [143:0] hdr;
        hdr = {da, 48'h02aa00000001, mpfc_pkg::CTRL_TYPE, op, q};
        sending = 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data  <= (i < 18) ? hdr[143 - 8 * i -: 8] : 8'h00;
            rx_eof   <= (i == 59);
            rx_good  <= (i == 59);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_eof   <= 1'b0;
        rx_good  <= 1'b0;
        sending = 1'b0;
    endtask : send_ctrl
endmodule : mpfc_station

/* File: testbench.sv */
// Purpose: self-checking bench for pause flow control
// Assumes: quantum shortened to 2 cycles
// Notes:   frame fcs is not checked, only the header
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s: expected %h seen %h", w, e, g); end end
module testbench;
    localparam int          QC  = 2;
    localparam logic [47:0] RDA = mpfc_pkg::RESERVED_DA;
    localparam logic [15:0] PO  = mpfc_pkg::PAUSE_OPCODE;
    localparam logic [7:0]  CT  = mpfc_pkg::CTRL_OFF;
    localparam logic [47:0] SRC = 48'h02a5a5a5a5a5;
    localparam logic [47:0] STA = 48'h02c3c3c3c3c3;
    localparam logic [15:0] PT  = 16'h0048;
    localparam logic [3:0]  ACC_CTRL [5] = '{4'h9, 4'h9, 4'h9, 4'hb, 4'h8};
    localparam logic [47:0] ACC_DA [5]   = '{RDA, STA, 48'h0a0b0c0d0e0f, 48'h0a0b0c0d0e0f, RDA};
    logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, pin = 1'b0, tx_req = 1'b0, prev_paused = 1'b0;
    logic [3:0]  level = 4'h0;
    logic        rx_valid, rx_eof, rx_good, rx_done, rx_is_ctrl, rx_pass;
    logic [7:0]  rx_data, pf_data;
    logic        tx_busy, tx_start, tx_paused, pf_valid, pf_last;
    int          bad_count = 0, n_compared = 0, wait_n = 0, n = 0;
    always #50 clk = ~clk;
    mpfc_top #(.QUANTUM_CYC(QC)) i_dut (.CLOCK(clk), .RESET_N(reset_n), .CE(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PAUSE_REQUEST_PIN(pin),
        .RX_FIFO_LEVEL(level), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_EOF(rx_eof),
        .RX_GOOD(rx_good), .RX_DONE(rx_done), .RX_IS_CTRL(rx_is_ctrl), .RX_PASS(rx_pass),
        .TX_REQ(tx_req), .TX_BUSY(tx_busy), .TX_START(tx_start), .TX_PAUSED(tx_paused),
        .PF_VALID(pf_valid), .PF_DATA(pf_data), .PF_LAST(pf_last));
    mpfc_station i_station (.clk(clk), .tx_start(tx_start), .tx_busy(tx_busy), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_eof(rx_eof), .rx_good(rx_good));
    always @(posedge clk) begin
        prev_paused <= tx_paused;
        if (tx_start === 1'b1) `CHK("start while paused", 1'b0, prev_paused)
    end
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin bad_count++; tally_and_finish(); end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK("read data", x, q)
        `CHK("read error", xe, e)
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        `CHK("write error", 1'b0, e)
    endtask : wr
    task automatic rx_check(input logic [47:0] da, input logic [15:0] op, input logic [15:0] q,
                            input logic ps, input logic pz);
        i_station.send_ctrl(da, op, q);
        @(posedge clk);
        `CHK("frame done", 1'b1, rx_done)
        `CHK("control flag", 1'b1, rx_is_ctrl)
        `CHK("pass flag", ps, rx_pass)
        `CHK("paused", pz, tx_paused)
    endtask : rx_check
    task automatic grab(input logic [15:0] t);
        logic [143:0] h;
        wait_n = 0;
        while (pf_valid !== 1'b1 && wait_n < 300) begin
            @(posedge clk);
            wait_n++;
        end
        if (wait_n >= 300) begin bad_count++; tally_and_finish(); end
        for (int i = 0; i < 64; i++) begin
            if (i < 18) h[143 - 8 * i -: 8] = pf_data;
            if (i == 63) `CHK("last byte flag", 1'b1, pf_last)
            @(posedge clk);
        end
        `CHK("pause frame header", {RDA, SRC, mpfc_pkg::CTRL_TYPE, PO, t}, h)
    endtask : grab
    task automatic quiet(input int c);
        int seen;
        seen = 0;
        repeat (c) begin
            @(posedge clk);
            if (pf_valid !== 1'b0) seen++;
        end
        `CHK("no pause frame", 0, seen)
    endtask : quiet
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        `CHK("paused after reset", 1'b0, tx_paused)
        rd(mpfc_pkg::STATUS_OFF, 32'h0, 1'b0);
        rd(CT, mpfc_pkg::CTRL_RESET, 1'b0);
        rd(mpfc_pkg::PTIME_OFF, 32'h0000ffff, 1'b0);
        rd(8'h1c, 32'h0, 1'b1);
        wr(mpfc_pkg::STA_LO_OFF, STA[31:0]);
        wr(mpfc_pkg::STA_HI_OFF, {16'h0, STA[47:32]});
        wr(mpfc_pkg::SRC_LO_OFF, SRC[31:0]);
        wr(mpfc_pkg::SRC_HI_OFF, {16'h0, SRC[47:32]});
        wr(mpfc_pkg::PTIME_OFF, {16'h0, PT});
        for (int m = 0; m < 4; m++) begin
            wr(CT, {26'h0, m[1:0], 4'h9});
            rx_check(RDA, PO, 16'h0000, 1'(4'b1010 >> m), 1'b0);
            rx_check(RDA, 16'h0002, 16'h0000, 1'(4'b0110 >> m), 1'b0);
        end
        for (int k = 0; k < 5; k++) begin
            wr(CT, {28'h0, ACC_CTRL[k]});
            rx_check(ACC_DA[k], PO, 16'h0100, 1'b0, 1'(5'b01011 >> k));
            wr(CT, 32'h00000009);
            rx_check(RDA, PO, 16'h0000, 1'b0, 1'b0);
        end
        tx_req <= 1'b1;
        rx_check(RDA, PO, 16'h0003, 1'b0, 1'b1);
        n = 1;
        while (tx_paused === 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        `CHK("pause cycles", 1'b1, n inside {[3 * QC - 1 : 3 * QC + 2]})
        rx_check(RDA, PO, 16'hffff, 1'b0, 1'b1);
        pin <= 1'b1;
        grab(PT);
        grab(PT);
        `CHK("repeat gap", 1'b1, wait_n inside {[(PT - 32) * QC - 68 : (PT - 32) * QC - 60]})
        pin <= 1'b0;
        grab(16'h0000);
        rx_check(RDA, PO, 16'h0000, 1'b0, 1'b0);
        wr(CT, 32'h0000000d);
        pin <= 1'b1;
        quiet(100);
        pin <= 1'b0;
        wr(CT, 32'h00000309);
        level <= 4'h4;
        grab(PT);
        level <= 4'h3;
        grab(16'h0000);
        wr(CT, 32'h00000301);
        level <= 4'h4;
        grab(PT);
        level <= 4'h0;
        quiet(100);
        tally_and_finish();
    end
endmodule : testbench
